// ==== common/ctis_regs.svh ====
// Overview of operation
// R1: Timer stop clears ready, timer keeps running
// R2: Break edge sets bit; break reset clears
// R3: Rx-ready sets on push, pop clears, resets
// R4: FIFO-full sets when full, pop clears
// R5: Status bit 0 mirrors transmitter ready
// R6: Interrupt low when status and mask match
// R7: Mask gates only interrupt, not status read
// R8: Preset written as two bytes, unreadable
// R9: Timer square wave period twice preset
// R10: Preset change waits for next half-period
// R11: Read at 1110 restarts from preset
// R12: Timer ready once per cycle; 1111 clears
// R13: Output select drives waveform onto pin
// R14: After reset timer mode runs continuously
// R15: Host keeps pin deselected until configured
// R16: Counter counts down, ready at 0000
// R17: Counter keeps counting past terminal count
// R18: Counter pin low at terminal, stop restores
// R19: Counter preset applies at next start
// R20: Live count readable as two bytes
// R21: Host stops counter before reading halves
// R22: Mode/clock code in aux_control bits 6:4
// R23: Count once per synchronised source edge
`ifndef CTIS_REGS_SVH
`define CTIS_REGS_SVH

// Register addresses on the four-bit host bus
`define CTIS_ADDR_AUX_CONTROL  4'h4
`define CTIS_ADDR_IRQ_STATUS   4'h5
`define CTIS_ADDR_IRQ_MASK     4'h5
`define CTIS_ADDR_COUNT_HIGH   4'h6
`define CTIS_ADDR_COUNT_LOW    4'h7
`define CTIS_ADDR_OUTPUT_SEL   4'hD
`define CTIS_ADDR_START_CMD    4'hE
`define CTIS_ADDR_STOP_CMD     4'hF

// Field positions
`define CTIS_ACR_MODE_HI       6
`define CTIS_ACR_MODE_LO       4
`define CTIS_OUTPUT_SELECT_CFG_OP3_HI       3
`define CTIS_OUTPUT_SELECT_CFG_OP3_LO       2
`define CTIS_ISR_TX_READY      0
`define CTIS_ISR_RX_READY      1
`define CTIS_ISR_BREAK         2
`define CTIS_ISR_COUNTER       3

// Output select codes for the counter pin
`define CTIS_OP3_PORT_BIT      2'h0
`define CTIS_OP3_COUNTER       2'h1

// Reset values
`define CTIS_RST_MODE          3'h6
`define CTIS_RST_PRESET        16'h0002
`define CTIS_RST_MASK          8'h00
`define CTIS_RST_OUTPUT_SEL    2'h0

// Timing counts
`define CTIS_DIV16_LAST        4'hF
`define CTIS_COUNT_ONE         16'h0001

`endif

// ==== common/ctis_pkg.sv ====
package ctis_pkg;

	// Counter/timer operating mode, from the top bit of the mode field
	typedef enum logic {
		CTIS_COUNTER,
		CTIS_TIMER
	} ctis_mode_e;

	// Selected clock source after synchronisation
	typedef enum logic [1:0] {
		CTIS_SRC_IN2,
		CTIS_SRC_CHAN_A_TX_CLOCK,
		CTIS_SRC_CHAN_B_TX_CLOCK,
		CTIS_SRC_XTAL
	} ctis_src_e;

endpackage : ctis_pkg

// ==== core/ctis_clk_sel.sv ====
`timescale 1ns/1ps
`include "ctis_regs.svh"

module ctis_clk_sel
	import ctis_pkg::*;
#(
	parameter int NSRC = 4
) (
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	input  wire logic [NSRC-1:0] src_i,
	input  wire logic [2:0] mode_code_i,
	output logic            tick_o
);

	logic [NSRC-1:0] sync1_reg;      // First stage, read only by second stage
	logic [NSRC-1:0] sync2_reg;      // Second stage, safe to use
	logic [NSRC-1:0] prev_reg;       // Delayed copy for edge detect
	logic [NSRC-1:0] rise;           // One-cycle rising edge strobes
	logic [3:0]      div_in2_reg;    // Divide-by-16 prescaler for input two
	logic [3:0]      div_xtal_reg;   // Divide-by-16 prescaler for crystal
	logic            in2_div16;
	logic            xtal_div16;
	ctis_src_e       src;

	// Two-flop synchroniser and edge detector for each asynchronous source
	genvar g;
	generate
		for (g = 0; g < NSRC; g++) begin : g_sync
			always_ff @(posedge clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					sync1_reg[g] <= 1'b0;
					sync2_reg[g] <= 1'b0;
					prev_reg[g]  <= 1'b0;
				end else begin
					sync1_reg[g] <= src_i[g];
					sync2_reg[g] <= sync1_reg[g];
					prev_reg[g]  <= sync2_reg[g];
				end
			end
			assign rise[g] = sync2_reg[g] & ~prev_reg[g]; // R23
		end
	endgenerate

	// Prescalers count source edges; sixteenth edge gives a tick
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			div_in2_reg  <= 4'h0;
			div_xtal_reg <= 4'h0;
		end else begin
			div_in2_reg  <= rise[CTIS_SRC_IN2] ? div_in2_reg + 4'h1 : div_in2_reg;
			div_xtal_reg <= rise[CTIS_SRC_XTAL] ? div_xtal_reg + 4'h1 : div_xtal_reg;
		end
	end

	assign in2_div16  = rise[CTIS_SRC_IN2] & (div_in2_reg == `CTIS_DIV16_LAST);
	assign xtal_div16 = rise[CTIS_SRC_XTAL] & (div_xtal_reg == `CTIS_DIV16_LAST);
	assign src        = ctis_src_e'(mode_code_i[1:0]);

	// Mode/clock selection table
	always_comb begin
		case (mode_code_i) // R22
			3'h0:    tick_o = rise[CTIS_SRC_IN2];
			3'h1:    tick_o = rise[CTIS_SRC_CHAN_A_TX_CLOCK];
			3'h2:    tick_o = rise[CTIS_SRC_CHAN_B_TX_CLOCK];
			3'h3:    tick_o = xtal_div16;
			3'h4:    tick_o = rise[CTIS_SRC_IN2];
			3'h5:    tick_o = in2_div16;
			3'h6:    tick_o = rise[CTIS_SRC_XTAL];
			3'h7:    tick_o = (src == CTIS_SRC_XTAL) & xtal_div16;
			default: tick_o = 1'b0;
		endcase
	end

endmodule : ctis_clk_sel

// ==== core/ctis_top.sv ====
`timescale 1ns/1ps
`include "ctis_regs.svh"

module ctis_top
	import ctis_pkg::*;
(
	input  wire logic       CLK_I,            // 25 MHz device clock
	input  wire logic       RESETN_I,         // Asynchronous reset, active low
	// Host register bus, synchronous to CLK_I
	input  wire logic       RD_I,             // One-cycle read strobe
	input  wire logic       WR_I,             // One-cycle write strobe
	input  wire logic [3:0] ADDR_I,           // Register address
	input  wire logic [7:0] WDATA_I,          // Write data
	output logic      [7:0] RDATA_O,          // Registered read data
	output logic            RVALID_O,         // Read data valid, one cycle
	// Counter/timer clock sources, asynchronous pins
	input  wire logic       EXT_IN2_I,        // ext_input_two
	input  wire logic       CHA_TXC_I,        // chan_a_tx_clock
	input  wire logic       CHB_TXC_I,        // chan_b_tx_clock
	input  wire logic       XTAL_CLK_I,       // crystal_clock
	// Channel A receiver and transmitter status, same clock domain
	input  wire logic       CHA_BREAK_EDGE_I, // Break start or end seen, pulse
	input  wire logic       CHA_BREAK_RST_I,  // Reset break change command, pulse
	input  wire logic       CHA_RX_PUSH_I,    // Character moved into FIFO, pulse
	input  wire logic       CHA_RX_POP_I,     // rx_holding read, pulse
	input  wire logic       CHA_FIFO_NONEMPTY_I, // FIFO holds a character after pop
	input  wire logic       CHA_FIFO_FULL_I,  // All three FIFO positions occupied
	input  wire logic       CHA_FFULL_SEL_I,  // chan_a_mode_one bit 6
	input  wire logic       CHA_TX_READY_I,   // chan_a_status transmitter ready
	input  wire logic       OUT_PORT_BIT3_I,  // Output port latch bit 3
	// Outputs
	output logic            CT_PIN_O,         // ct_output_pin level when driven
	output logic            CT_PIN_OE_O,      // ct_output_pin drive enable
	output logic            IRQ_N_O           // irq_out_n, active low
);

	// Host-visible control state
	// None of these read back; software keeps its own copies
	logic [2:0]  mode_code_reg;      // aux_control bits 6:4
	logic [1:0]  out_sel_reg;        // output_select_cfg bits 3:2
	logic [7:0]  irq_mask_reg;       // irq_mask
	logic [7:0]  preset_high_reg;    // count_preset_high, write-only
	logic [7:0]  preset_low_reg;     // count_preset_low, write-only
	logic [7:0]  rdata_reg;
	logic        rvalid_reg;

	// Counter/timer state
	// count_reg doubles as the live count that the host reads
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic        wave_reg;           // Timer square wave, high half first
	logic        wave_next;
	logic        running_reg;        // Counter mode counting
	logic        running_next;
	logic        ct_ready_reg;       // Counter ready status
	logic        ct_ready_next;

	// Channel A status bits
	// Set by receiver events, cleared by commands or holding reads
	logic        break_chg_reg;
	logic        rx_flag_reg;
	logic        rx_flag_next;
	logic        pop_pending_reg;    // Pop seen, re-arm next cycle if data left

	// Decoded bus actions
	// Single-cycle strobes, one per bus access
	logic        wr_aux;
	logic        wr_aux_cnt;         // Mode write that selects counter mode
	logic        wr_mask;
	logic        wr_high;
	logic        wr_low;
	logic        wr_opsel;
	logic        cmd_start;
	logic        cmd_stop;
	logic        rd_status;
	logic        rd_high;
	logic        rd_low;
	logic        tick;
	logic        at_one;
	logic [15:0] preset;
	logic [7:0]  irq_status;
	logic [7:0]  rd_mux;
	logic        ct_wave;
	ctis_mode_e  mode;

	// Address decode; reads and writes share addresses with distinct meaning
	// Start and stop are reads with side effects, so a stray read of
	// either command address restarts the counter/timer or stops the counter
	assign wr_aux    = WR_I & (ADDR_I == `CTIS_ADDR_AUX_CONTROL);
	assign wr_mask   = WR_I & (ADDR_I == `CTIS_ADDR_IRQ_MASK);
	assign wr_high   = WR_I & (ADDR_I == `CTIS_ADDR_COUNT_HIGH); // R8
	assign wr_low    = WR_I & (ADDR_I == `CTIS_ADDR_COUNT_LOW);  // R8
	assign wr_opsel  = WR_I & (ADDR_I == `CTIS_ADDR_OUTPUT_SEL);
	assign cmd_start = RD_I & (ADDR_I == `CTIS_ADDR_START_CMD);  // R11
	assign cmd_stop  = RD_I & (ADDR_I == `CTIS_ADDR_STOP_CMD);   // R12
	assign rd_status = RD_I & (ADDR_I == `CTIS_ADDR_IRQ_STATUS);
	assign rd_high   = RD_I & (ADDR_I == `CTIS_ADDR_COUNT_HIGH);
	assign rd_low    = RD_I & (ADDR_I == `CTIS_ADDR_COUNT_LOW);
	// Entering counter mode parks the counter until the next start
	assign wr_aux_cnt = wr_aux & ~WDATA_I[`CTIS_ACR_MODE_HI]; // R16

	// Preset as one word; mode from the top bit of the mode field
	// Reload is a tick seen at one, so a half-period spans preset ticks
	assign preset = {preset_high_reg, preset_low_reg};
	assign mode   = ctis_mode_e'(mode_code_reg[2]);
	assign at_one = (count_reg == `CTIS_COUNT_ONE);

	// Clock source selection and synchronisation
	// Each source passes two flops and an edge detector, so a tick
	// trails its pin edge by about two device clocks; sources must
	// stay below half the device clock or edges are lost
	ctis_clk_sel #(
		.NSRC        (4)
	) u_clk_sel (
		.clk_i       (CLK_I),
		.resetn_i    (RESETN_I),
		.src_i       ({XTAL_CLK_I, CHB_TXC_I, CHA_TXC_I, EXT_IN2_I}),
		.mode_code_i (mode_code_reg),
		.tick_o      (tick)
	);

	// Write-only configuration registers
	// Presets are copied into the count only at a reload, which keeps
	// a half-period in progress undisturbed
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			mode_code_reg   <= `CTIS_RST_MODE; // R14
			out_sel_reg     <= `CTIS_RST_OUTPUT_SEL;
			irq_mask_reg    <= `CTIS_RST_MASK;
			// Reset preset matches the reset count
			preset_high_reg <= 8'(`CTIS_RST_PRESET >> 8);
			preset_low_reg  <= 8'(`CTIS_RST_PRESET);
		end else begin
			if (wr_aux)
				mode_code_reg <= WDATA_I[`CTIS_ACR_MODE_HI:`CTIS_ACR_MODE_LO];
			if (wr_opsel)
				out_sel_reg <= WDATA_I[`CTIS_OUTPUT_SELECT_CFG_OP3_HI:`CTIS_OUTPUT_SELECT_CFG_OP3_LO];
			if (wr_mask)
				irq_mask_reg <= WDATA_I;
			if (wr_high)
				preset_high_reg <= WDATA_I;
			if (wr_low)
				preset_low_reg <= WDATA_I;
		end
	end

	// Counter/timer next state
	// Stop is applied first and a tick later, so a ready set in the
	// same cycle as a stop wins and no wave cycle goes unreported
	always_comb begin
		count_next    = count_reg;
		wave_next     = wave_reg;
		running_next  = running_reg;
		ct_ready_next = ct_ready_reg;
		if (cmd_stop) begin
			// Timer ignores stop apart from the flag; counter halts
			ct_ready_next = 1'b0; // R1
			if (mode == CTIS_COUNTER) begin
				running_next = 1'b0; // R18
				wave_next    = 1'b1; // R18
			end
		end
		if (cmd_start) begin
			// Abandon the cycle in progress and reload
			count_next   = preset;  // R11 R19
			wave_next    = 1'b1;
			running_next = 1'b1;
		end else if (tick) begin
			case (mode)
				CTIS_TIMER: begin
					if (at_one) begin
						// Preset sampled only at the half-period boundary
						count_next = preset;    // R9 R10
						wave_next  = ~wave_reg; // R9
						// Wave returning high closes one full cycle
						if (!wave_reg)
							ct_ready_next = 1'b1; // R12
					end else begin
						count_next = count_reg - `CTIS_COUNT_ONE; // R9
					end
				end
				CTIS_COUNTER: begin
					if (running_reg) begin
						// Wraps through zero and keeps going
						count_next = count_reg - `CTIS_COUNT_ONE; // R16 R17
						// Leaving one means the count has reached zero
						if (at_one) begin
							ct_ready_next = 1'b1; // R16
							wave_next     = 1'b0; // R18
						end
					end
				end
				default: count_next = count_reg;
			endcase
		end
		if (wr_aux_cnt) begin
			// Counter mode waits for a start with its pin high
			running_next = 1'b0; // R16
			wave_next    = 1'b1; // R18
		end
	end

	// Counter/timer registers; reset leaves the timer running
	// Reset count equals the reset preset so the first half-period is full
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			count_reg    <= `CTIS_RST_PRESET; // R14
			wave_reg     <= 1'b1;
			running_reg  <= 1'b1;
			ct_ready_reg <= 1'b0;
		end else begin
			count_reg    <= count_next;
			wave_reg     <= wave_next;
			running_reg  <= running_next;
			ct_ready_reg <= ct_ready_next;
		end
	end

	// Receive status: pop clears, a push in the same cycle wins
	// In receiver-ready mode a pop leaves the bit low for one cycle
	// before it sets again, so software sees the pop with data left
	always_comb begin
		rx_flag_next = rx_flag_reg;
		if (CHA_RX_POP_I)
			rx_flag_next = 1'b0; // R3 R4
		if (pop_pending_reg && !CHA_FFULL_SEL_I && CHA_FIFO_NONEMPTY_I)
			rx_flag_next = 1'b1; // R3
		if (CHA_RX_PUSH_I && (!CHA_FFULL_SEL_I || CHA_FIFO_FULL_I))
			rx_flag_next = 1'b1; // R3 R4
	end

	// Channel A status flags
	// Pop is remembered one cycle so the FIFO state after the pop is used
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			break_chg_reg   <= 1'b0;
			rx_flag_reg     <= 1'b0;
			pop_pending_reg <= 1'b0;
		end else begin
			// Edge detection beats a simultaneous reset command
			break_chg_reg   <= CHA_BREAK_EDGE_I | (break_chg_reg & ~CHA_BREAK_RST_I); // R2
			rx_flag_reg     <= rx_flag_next;
			pop_pending_reg <= CHA_RX_POP_I;
		end
	end

	// Status word; upper four bits belong to other blocks and read zero
	// Tx ready is taken straight from its input, so it follows at once
	always_comb begin
		irq_status = 8'h00;
		irq_status[`CTIS_ISR_TX_READY] = CHA_TX_READY_I; // R5
		irq_status[`CTIS_ISR_RX_READY] = rx_flag_reg;
		irq_status[`CTIS_ISR_BREAK]    = break_chg_reg;
		irq_status[`CTIS_ISR_COUNTER]  = ct_ready_reg;
	end

	// Read multiplexer; status is never masked, presets never read back
	// Count halves are live; software should stop the counter between reads
	assign rd_mux = rd_status ? irq_status :            // R7
	                rd_high   ? count_reg[15:8] :       // R20
	                rd_low    ? count_reg[7:0]  :       // R20
	                8'h00;                              // R8

	// Registered read port
	// Read data is zero outside the valid cycle
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rdata_reg  <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg  <= RD_I ? rd_mux : 8'h00;
			rvalid_reg <= RD_I;
		end
	end

	assign RDATA_O  = rdata_reg;
	assign RVALID_O = rvalid_reg;

	// Interrupt: any unmasked status bit pulls the line low
	// Mask acts here only; status reads and the pin ignore it
	assign IRQ_N_O = ~|(irq_status & irq_mask_reg); // R6 R7

	// Counter pin: open-collector when showing the counter/timer
	// Drive enable follows the low phase of the wave; the wire's
	// pull-up supplies the high phase
	assign ct_wave = wave_reg;
	always_comb begin
		case (out_sel_reg)
			`CTIS_OP3_PORT_BIT: begin
				CT_PIN_O    = ~OUT_PORT_BIT3_I;
				CT_PIN_OE_O = 1'b1;
			end
			`CTIS_OP3_COUNTER: begin
				CT_PIN_O    = 1'b0;     // R13
				CT_PIN_OE_O = ~ct_wave; // R13 R18
			end
			default: begin
				// Channel B clock outputs live elsewhere; pin released
				CT_PIN_O    = 1'b0;
				CT_PIN_OE_O = 1'b0;
			end
		endcase
	end

endmodule : ctis_top

// ==== dv/ctis_monitor.sv ====
`timescale 1ns/1ps

module ctis_monitor (
	input wire logic       CLK_I,
	input wire logic       RESETN_I,
	input wire logic       RD_I,
	input wire logic       WR_I,
	input wire logic [3:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic [7:0] RDATA_O,
	input wire logic       RVALID_O,
	input wire logic       CHA_BREAK_EDGE_I,
	input wire logic       CHA_BREAK_RST_I,
	input wire logic       CHA_TX_READY_I,
	input wire logic       CT_PIN_OE_O,
	input wire logic       IRQ_N_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);
	logic [7:0] mask_reg;                      // Shadow of the mask as the host wrote it
	wire        rd_stat = RD_I && ADDR_I == 4'h5; // Status read request

	// Shadow follows host mask writes, so the interrupt can be judged from the bus alone
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I)
			mask_reg <= 8'h00;
		else if (WR_I && ADDR_I == 4'h5)
			mask_reg <= WDATA_I;
	end

	// Break edge, then a status read two cycles later, no break reset in between
	sequence s_brk_rd;
		CHA_BREAK_EDGE_I ##1 !CHA_BREAK_RST_I ##1 (rd_stat && !CHA_BREAK_RST_I);
	endsequence

	property p_rd_valid; RD_I |=> RVALID_O; endproperty
	property p_no_valid; !RD_I |=> !RVALID_O; endproperty
	property p_idle_zero; !RVALID_O |-> RDATA_O == 8'h00; endproperty
	property p_unmapped_zero; RD_I && !(ADDR_I inside {4'h5, 4'h6, 4'h7}) |=> RDATA_O == 8'h00; endproperty
	property p_tx_mirror; rd_stat |=> RDATA_O[0] == $past(CHA_TX_READY_I) && RDATA_O[7:4] == 4'h0; endproperty
	property p_break_set; s_brk_rd |=> RDATA_O[2]; endproperty
	property p_irq; rd_stat |=> $past(IRQ_N_O) == ((RDATA_O & $past(mask_reg)) == 8'h00); endproperty
	property p_reset_state; $rose(RESETN_I) |-> IRQ_N_O && CT_PIN_OE_O; endproperty

	a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
	a_no_valid: assert property (p_no_valid) else $error("valid without read");
	a_idle_zero: assert property (p_idle_zero) else $error("data outside valid");
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("nonzero read data");
	a_tx_mirror: assert property (p_tx_mirror) else $error("tx ready not mirrored");
	a_break_set: assert property (p_break_set) else $error("break bit not set");
	a_irq: assert property (p_irq) else $error("interrupt disagrees with mask");
	a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
endmodule : ctis_monitor

bind ctis_top ctis_monitor u_mon (.*);

// ==== dv/ctis_host_model.sv ====
`timescale 1ns/1ps

module ctis_host_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] rdata_i,
	input  wire logic       rvalid_i,
	output logic            rd_o,
	output logic            wr_o,
	output logic      [3:0] addr_o,
	output logic      [7:0] wdata_o
);
	// Bus idle from time zero
	initial begin
		rd_o = 1'b0;
		wr_o = 1'b0;
		addr_o = 4'h0;
		wdata_o = 8'h00;
	end

	// One-cycle write; released lines flip so stale values cannot pass
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask : wr

	// One-cycle read; data taken at the edge that samples valid high
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(posedge clk_i);
		d = rvalid_i ? rdata_i : 8'hxx;
	endtask : rd
endmodule : ctis_host_model

// ==== dv/tb_counter_timer_irq_status.sv ====
`timescale 1ns/1ps
`define CHK(nm, a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
	$display("mismatch %s exp %0h got %0h", nm, (e), (a)); end end

module tb_counter_timer_irq_status;
	logic       clk, rst_n, tx_rdy, ffull_sel, nonempty, full, in2, xtal, xtal_en, chan_a_tx_clock;
	logic [3:0] ev;       // Break edge, break reset, push, pop
	logic [7:0] d;
	wire        rd, wr, rvalid, ct_pin, ct_oe, irq_n;
	wire  [3:0] addr;
	wire  [7:0] wdata, rdata;
	int         bad_count, n_tests, n;

	ctis_top uut (.CLK_I(clk), .RESETN_I(rst_n), .RD_I(rd), .WR_I(wr), .ADDR_I(addr), .WDATA_I(wdata),
		.RDATA_O(rdata), .RVALID_O(rvalid), .EXT_IN2_I(in2), .CHA_TXC_I(chan_a_tx_clock), .CHB_TXC_I(1'b0),
		.XTAL_CLK_I(xtal), .CHA_BREAK_EDGE_I(ev[3]), .CHA_BREAK_RST_I(ev[2]), .CHA_RX_PUSH_I(ev[1]),
		.CHA_RX_POP_I(ev[0]), .CHA_FIFO_NONEMPTY_I(nonempty), .CHA_FIFO_FULL_I(full),
		.CHA_FFULL_SEL_I(ffull_sel), .CHA_TX_READY_I(tx_rdy), .OUT_PORT_BIT3_I(1'b1),
		.CT_PIN_O(ct_pin), .CT_PIN_OE_O(ct_oe), .IRQ_N_O(irq_n));
	ctis_host_model host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .rd_o(rd), .wr_o(wr),
		.addr_o(addr), .wdata_o(wdata));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Crystal toggles each cycle while enabled: one tick every two cycles
	always @(posedge clk) begin
		if (xtal_en)
			xtal <= ~xtal;
	end

	task automatic pulse(input logic [3:0] v);
		@(posedge clk);
		ev <= v;
		@(posedge clk);
		ev <= 4'h0;
	endtask : pulse
	// Slow edges on the chosen pins: p is {chan_a_tx_clock, ext_input_two}
	task automatic tick_src(input int k, input logic [1:0] p);
		repeat (k) begin
			@(posedge clk);
			{chan_a_tx_clock, in2} <= p;
			repeat (4) @(posedge clk);
			{chan_a_tx_clock, in2} <= 2'b00;
			repeat (4) @(posedge clk);
		end
	endtask : tick_src
	task automatic rstat(input logic [7:0] e);
		host.rd(4'h5, d);
		`CHK("status", d, e)
	endtask : rstat
	// Waits for the wave to rise (enable falls), counting cycles; sampled mid-cycle
	task automatic fall(inout int c);
		repeat (60) if (ct_oe !== 1'b1) begin @(negedge clk); c++; end
		repeat (60) if (ct_oe !== 1'b0) begin @(negedge clk); c++; end
	endtask : fall
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		conclude();
	end

	initial begin
		{rst_n, ffull_sel, nonempty, full, in2, xtal, xtal_en, chan_a_tx_clock, ev} = '0;
		tx_rdy = 1'b1;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		`CHK("oe", ct_oe, 1'b1)
		`CHK("pin", ct_pin, 1'b0)
		rstat(8'h01);
		host.rd(4'h0, d);
		`CHK("unmapped", d, 8'h00)
		$display("test reset done");
		@(posedge clk) tx_rdy <= 1'b0;
		rstat(8'h00);
		pulse(4'h8);
		rstat(8'h04);
		host.wr(4'h5, 8'h04);
		@(negedge clk) `CHK("irq", irq_n, 1'b0)
		host.wr(4'h5, 8'h02);
		@(negedge clk) `CHK("irq", irq_n, 1'b1)
		rstat(8'h04);
		pulse(4'h4);
		rstat(8'h00);
		@(posedge clk) nonempty <= 1'b1;
		pulse(4'h2);
		rstat(8'h02);
		`CHK("irq", irq_n, 1'b0)
		pulse(4'h1);
		rstat(8'h02);
		@(posedge clk) nonempty <= 1'b0;
		pulse(4'h1);
		rstat(8'h00);
		@(posedge clk) ffull_sel <= 1'b1;
		pulse(4'h2);
		rstat(8'h00);
		@(posedge clk) full <= 1'b1;
		pulse(4'h2);
		rstat(8'h02);
		pulse(4'h1);
		rstat(8'h00);
		host.wr(4'h5, 8'h00);
		$display("test status done");
		host.wr(4'hD, 8'h04);
		@(posedge clk) xtal_en <= 1'b1;
		fall(n); n = 0; fall(n); `CHK("period", n, 8)
		`CHK("pin", ct_pin, 1'b0)
		host.wr(4'h7, 8'h03);
		host.rd(4'hE, d);
		fall(n); n = 0; fall(n); `CHK("period", n, 12)
		rstat(8'h08);
		host.rd(4'hF, d);
		rstat(8'h00);
		fall(n); n = 0; fall(n); `CHK("period", n, 12)
		$display("test timer done");
		@(posedge clk) xtal_en <= 1'b0;
		host.wr(4'h4, 8'h00);
		host.wr(4'h7, 8'h05);
		host.rd(4'hE, d);
		host.rd(4'h7, d);
		`CHK("count_lo", d, 8'h05)
		tick_src(4, 2'b01);
		host.rd(4'h7, d);
		`CHK("count_lo", d, 8'h01)
		`CHK("oe", ct_oe, 1'b0)
		tick_src(1, 2'b01);
		rstat(8'h08);
		`CHK("oe", ct_oe, 1'b1)
		tick_src(1, 2'b01);
		host.rd(4'h6, d);
		`CHK("count_hi", d, 8'hff)
		host.rd(4'hF, d);
		rstat(8'h00);
		`CHK("oe", ct_oe, 1'b0)
		host.wr(4'h7, 8'h09);
		host.rd(4'h7, d);
		`CHK("count_lo", d, 8'hff)
		host.rd(4'hE, d);
		host.rd(4'h7, d);
		`CHK("count_lo", d, 8'h09)
		host.wr(4'h4, 8'h10);
		tick_src(1, 2'b10);
		host.rd(4'h7, d);
		`CHK("count_lo", d, 8'h09)
		host.rd(4'hE, d);
		tick_src(2, 2'b01);
		host.rd(4'h7, d);
		`CHK("count_lo", d, 8'h09)
		tick_src(3, 2'b10);
		host.rd(4'h7, d);
		`CHK("count_lo", d, 8'h06)
		$display("test counter done");
		conclude();
	end
endmodule : tb_counter_timer_irq_status
